// file: hdl/ccs_clock_ctrl.sv
// Purpose: Clock mode decode, start-up timing and fail-safe clock handover
// Assumes: Mode field is stable configuration, captured during reset
// Notes: Wishbone classic slave; ack one cycle after the request edge
//
// Overview of operation
// - Eight clock modes are chosen by a three-bit mode field.
// - External clock mode clocks from osc input and frees pin4 as I/O.
// - RC clock-out mode drives oscillator frequency divided by four on pin4.
// - RC I/O mode frees the osc output pin as port A bit four.
// - Internal clock-out mode drives clock/4 on pin4, frees pin5.
// - Internal I/O mode frees both pin4 and pin5 as I/O.
// - Crystal modes count 1024 osc edges after power-up delay or wake.
// - Execution is held while the start-up timer counts.
// - External clock mode skips the start-up timer entirely.
// - Logic is static; a stopped clock freezes all state intact.
// - Amplifier gain follows crystal mode: low, medium or high.
// - Internal oscillator modes wait about five microseconds after reset or wake.
// - Loss of external clock switches the system clock to internal.
// - Two internal sources exist: fast 8 MHz and slow 31 kHz.
// - Software selects external or internal clock by source select bit.
// - Two-speed start-up lets code run during oscillator start-up.
// - Source select bit sits at bit zero of the control register.
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module ccs_clock_ctrl #(
    parameter int unsigned FAIL_TIMEOUT = 256
) (
    input wire logic clk,
    input wire logic rst,
    input wire ccs_pkg::ccs_wb_req_t wb_req,
    output ccs_pkg::ccs_wb_rsp_t wb_rsp,
    input wire logic [2:0] clock_mode_select,
    input wire logic osc_input_pin,
    input wire logic por_event,
    input wire logic wake_event,
    input wire logic powerup_delay_timer_enable,
    input wire logic powerup_delay_timer_expired,
    output logic cpu_hold,
    output ccs_pkg::ccs_src_t sysclk_source,
    output ccs_pkg::ccs_gain_t amp_gain,
    output logic pin4_o,
    output logic pin4_oe,
    output logic pin4_gpio,
    output logic pin5_gpio,
    output logic irq
);
    import ccs_pkg::*;

    typedef struct packed {
        ccs_st_t st;
        ccs_mode_t mode;
        logic [10:0] ost_cnt;
        logic [7:0] wake_cnt;
        logic [15:0] fail_cnt;
        logic failed;
        logic [2:0] ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] div;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
    } ccs_state_t;

    ccs_state_t s_q;
    ccs_state_t s_d;

    function automatic logic is_crystal(input ccs_mode_t m);
        return m == LOW_GAIN_CRYSTAL_MODE || m == MEDIUM_GAIN_CRYSTAL_MODE
            || m == HIGH_GAIN_CRYSTAL_MODE;
    endfunction : is_crystal

    function automatic logic is_internal(input ccs_mode_t m);
        return m == INTERNAL_OSC_QUARTER_CLOCK_OUT_MODE || m == INTERNAL_OSC_IO_MODE;
    endfunction : is_internal

    // First step after the power-up delay or a wake
    function automatic ccs_st_t start_state(input ccs_mode_t m);
        if (is_crystal(m)) begin
            return ST_OST;
        end
        if (is_internal(m)) begin
            return ST_INT_WAKE;
        end
        return ST_RUN;
    endfunction : start_state

    logic osc_edge;
    logic two_speed;
    logic bus_req;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    ccs_src_t int_src;

    assign osc_edge = s_q.osc_s2 & ~s_q.osc_s3;
    assign two_speed = s_q.ctrl[CTRL_TWO_SPEED];
    assign bus_req = wb_req.cyc & wb_req.stb & ~s_q.ack;
    assign int_src = s_q.ctrl[CTRL_SLOW_INT] ? SRC_SLOW_INT : SRC_FAST_INT;

    always_comb begin
        s_d = s_q;
        irq_set = 3'h0;
        irq_clr = 3'h0;
        s_d.osc_s1 = osc_input_pin;
        s_d.osc_s2 = s_q.osc_s1;
        s_d.osc_s3 = s_q.osc_s2;

        // Quarter-rate divider: osc edges in RC clock-out mode, system clock otherwise
        if (s_q.mode == RC_OSC_QUARTER_CLOCK_OUT_MODE) begin
            s_d.div = s_q.div + 2'(osc_edge);
        end else begin
            s_d.div = s_q.div + 2'h1;
        end

        unique case (s_q.st)
            ST_POWERUP_DELAY_TIMER: begin
                if (!powerup_delay_timer_enable || powerup_delay_timer_expired) begin
                    s_d.st = start_state(s_q.mode);
                end
            end
            ST_OST: begin
                if (osc_edge) begin
                    if (s_q.ost_cnt == OST_LAST) begin
                        s_d.st = ST_RUN;
                        irq_set[IRQ_OST_DONE] = 1'b1;
                    end else begin
                        s_d.ost_cnt = s_q.ost_cnt + 11'h1;
                    end
                end
            end
            ST_INT_WAKE: begin
                if (s_q.wake_cnt == WAKE_LAST) begin
                    s_d.st = ST_RUN;
                    irq_set[IRQ_WAKE_DONE] = 1'b1;
                end else begin
                    s_d.wake_cnt = s_q.wake_cnt + 8'h1;
                end
            end
            ST_RUN: begin
            end
        endcase

        // Fail monitor watches osc edges once an external source is running
        if (!is_internal(s_q.mode) && s_q.st == ST_RUN && !s_q.failed) begin
            if (osc_edge) begin
                s_d.fail_cnt = 16'h0;
            end else if (s_q.fail_cnt == 16'(FAIL_TIMEOUT - 1)) begin
                s_d.failed = 1'b1;
                irq_set[IRQ_CLK_FAIL] = 1'b1;
            end else begin
                s_d.fail_cnt = s_q.fail_cnt + 16'h1;
            end
        end

        // Reset-like events restart the start-up sequence from zero
        if (por_event || wake_event) begin
            s_d.ost_cnt = 11'h0;
            s_d.wake_cnt = 8'h0;
            s_d.fail_cnt = 16'h0;
            s_d.failed = 1'b0;
            s_d.st = por_event ? ST_POWERUP_DELAY_TIMER : start_state(s_q.mode);
        end

        // Register slave
        s_d.ack = bus_req;
        s_d.rdata = 32'h0;
        if (bus_req && wb_req.we && wb_req.sel[0]) begin
            unique case (wb_req.adr)
                REG_CTRL: s_d.ctrl = wb_req.dat[2:0];
                REG_IRQ_STAT: irq_clr = wb_req.dat[2:0];
                REG_IRQ_MASK: s_d.irq_mask = wb_req.dat[2:0];
                default: ;
            endcase
        end
        if (bus_req && !wb_req.we) begin
            unique case (wb_req.adr)
                REG_CTRL: s_d.rdata[2:0] = s_q.ctrl;
                REG_STAT: begin
                    s_d.rdata[STAT_MODE +: 3] = s_q.mode;
                    s_d.rdata[STAT_HOLD] = cpu_hold;
                    s_d.rdata[STAT_FAILED] = s_q.failed;
                    s_d.rdata[STAT_OST] = s_q.st == ST_OST;
                    s_d.rdata[STAT_SRC +: 2] = sysclk_source;
                end
                REG_IRQ_STAT: s_d.rdata[2:0] = s_q.irq_stat;
                REG_IRQ_MASK: s_d.rdata[2:0] = s_q.irq_mask;
                default: ;
            endcase
        end
        // A new event wins over a clear written in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
    end

    // Nothing moves without a clock edge, so a stopped clock keeps all state
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{st: ST_POWERUP_DELAY_TIMER, mode: ccs_mode_t'(clock_mode_select),
                     ctrl: CTRL_RESET, irq_stat: IRQ_RESET,
                     irq_mask: IRQ_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        sysclk_source = SRC_EXT;
        if (is_internal(s_q.mode) || s_q.ctrl[CTRL_SCS] || s_q.failed
            || (two_speed && s_q.st == ST_OST)) begin
            sysclk_source = int_src;
        end
    end

    always_comb begin
        unique case (s_q.mode)
            LOW_GAIN_CRYSTAL_MODE: amp_gain = GAIN_LOW;
            MEDIUM_GAIN_CRYSTAL_MODE: amp_gain = GAIN_MED;
            HIGH_GAIN_CRYSTAL_MODE: amp_gain = GAIN_HIGH;
            default: amp_gain = GAIN_OFF;
        endcase
    end

    // Execution stalls during every start-up wait, except the crystal count when two-speed is on
    assign cpu_hold = s_q.st == ST_POWERUP_DELAY_TIMER || s_q.st == ST_INT_WAKE
        || (s_q.st == ST_OST && !two_speed);

    assign pin4_oe = s_q.mode == RC_OSC_QUARTER_CLOCK_OUT_MODE
        || s_q.mode == INTERNAL_OSC_QUARTER_CLOCK_OUT_MODE;
    assign pin4_o = pin4_oe & s_q.div[1];
    assign pin4_gpio = s_q.mode == EXT_CLOCK_INPUT_MODE
        || s_q.mode == RC_OSC_IO_MODE
        || s_q.mode == INTERNAL_OSC_IO_MODE;
    assign pin5_gpio = is_internal(s_q.mode);

    assign irq = |(s_q.irq_stat & s_q.irq_mask);
    assign wb_rsp.ack = s_q.ack;
    assign wb_rsp.dat = s_q.rdata;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence ost_leave;
        $past(s_q.st) == ST_OST ##0 s_q.st == ST_RUN;
    endsequence

    chk_hold_during_ost: assert property (
        s_q.st == ST_OST && !two_speed |-> cpu_hold)
        else $error("execution not held during start-up count");

    chk_ost_full_count: assert property (
        ost_leave ##0 (!$past(por_event) && !$past(wake_event))
        |-> $past(s_q.ost_cnt) == OST_LAST)
        else $error("start-up count released early");

    chk_ec_no_ost: assert property (
        s_q.mode == EXT_CLOCK_INPUT_MODE && wake_event && !por_event
        |=> s_q.st == ST_RUN && !cpu_hold)
        else $error("external clock mode delayed after wake");

    // Fifty held cycles in groups of eight, so the tools unroll little
    sequence int_wake_hold;
        cpu_hold [*8] ##1 cpu_hold [*8] ##1 cpu_hold [*8] ##1 cpu_hold [*8]
            ##1 cpu_hold [*8] ##1 cpu_hold [*8] ##1 cpu_hold [*2];
    endsequence

    chk_int_wake_time: assert property (
        is_internal(s_q.mode) && wake_event && !por_event
        |=> int_wake_hold ##1 !cpu_hold)
        else $error("internal wake delay wrong");

    chk_gain_map: assert property (
        s_q.mode == HIGH_GAIN_CRYSTAL_MODE |-> amp_gain == GAIN_HIGH)
        else $error("high gain not selected");

    chk_rc_quarter_clock_out: assert property (
        s_q.mode == RC_OSC_QUARTER_CLOCK_OUT_MODE |-> pin4_oe && !pin4_gpio)
        else $error("clock out not driven in RC mode");

    chk_intio_pins: assert property (
        s_q.mode == INTERNAL_OSC_IO_MODE |-> pin4_gpio && pin5_gpio && !pin4_oe)
        else $error("internal I/O pins not released");

    chk_fail_switch: assert property (
        $rose(s_q.failed) |-> sysclk_source != SRC_EXT && s_q.irq_stat[IRQ_CLK_FAIL])
        else $error("failed clock not replaced");

    chk_scs_select: assert property (
        s_q.ctrl[CTRL_SCS] |-> sysclk_source == int_src)
        else $error("source select ignored");
endmodule : ccs_clock_ctrl

// file: include/ccs_pkg.sv
// Purpose: Shared types and constants of the clock source controller
// Assumes: 10 MHz system clock
// Notes: Register offsets are byte addresses on a 32-bit bus
package ccs_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned OST_COUNT = 1024;
    localparam int unsigned INT_WAKE_NS = 5000;
    localparam int unsigned INT_WAKE_CYC =
        (INT_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [10:0] OST_LAST = 11'(OST_COUNT - 1);
    localparam logic [7:0] WAKE_LAST = 8'(INT_WAKE_CYC - 1);

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

    localparam int CTRL_SCS = 0;
    localparam int CTRL_TWO_SPEED = 1;
    localparam int CTRL_SLOW_INT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    localparam int IRQ_OST_DONE = 0;
    localparam int IRQ_CLK_FAIL = 1;
    localparam int IRQ_WAKE_DONE = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    localparam int STAT_MODE = 0;
    localparam int STAT_HOLD = 3;
    localparam int STAT_FAILED = 4;
    localparam int STAT_OST = 5;
    localparam int STAT_SRC = 6;

    typedef enum logic [2:0] {
        EXT_CLOCK_INPUT_MODE = 3'h0,
        LOW_GAIN_CRYSTAL_MODE = 3'h1,
        MEDIUM_GAIN_CRYSTAL_MODE = 3'h2,
        HIGH_GAIN_CRYSTAL_MODE = 3'h3,
        RC_OSC_QUARTER_CLOCK_OUT_MODE = 3'h4,
        RC_OSC_IO_MODE = 3'h5,
        INTERNAL_OSC_QUARTER_CLOCK_OUT_MODE = 3'h6,
        INTERNAL_OSC_IO_MODE = 3'h7
    } ccs_mode_t;

    typedef enum logic [1:0] {
        SRC_EXT = 2'h0,
        SRC_FAST_INT = 2'h1,
        SRC_SLOW_INT = 2'h2
    } ccs_src_t;

    typedef enum logic [1:0] {
        GAIN_OFF = 2'h0,
        GAIN_LOW = 2'h1,
        GAIN_MED = 2'h2,
        GAIN_HIGH = 2'h3
    } ccs_gain_t;

    typedef enum {ST_POWERUP_DELAY_TIMER, ST_OST, ST_INT_WAKE, ST_RUN} ccs_st_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ccs_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ccs_wb_rsp_t;
endpackage : ccs_pkg

// file: testbench/ccs_osc_model.sv
// Purpose: Crystal or external clock source on the oscillator input
// Assumes: Toggles every two system clocks while running
// Notes: A stopped source stands still at its last level, as a dead crystal would
`timescale 1ns/1ps
module ccs_osc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    output logic osc,
    output int edges
);
    logic ph_q = 1'b0;
    initial begin
        osc = 1'b0;
        edges = 0;
    end
    always @(posedge clk) begin
        if (rst) begin
            edges <= 0;
            ph_q <= 1'b0;
        end else if (en) begin
            ph_q <= ~ph_q;
            if (ph_q) begin
                osc <= ~osc;
                if (!osc) begin
                    edges <= edges + 1;
                end
            end
        end
    end
endmodule : ccs_osc_model

// file: testbench/clock_source_mode_startup_tb_top.sv
// Purpose: Self-checking bench for the clock source controller
// Assumes: Power-up delay off except in the power-on test
// Notes: FAIL_TIMEOUT shortened to 16 to keep the loss test short
`timescale 1ns/1ps
module clock_source_mode_startup_tb_top;
    import ccs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ccs_wb_req_t wb_req = '0;
    ccs_wb_rsp_t wb_rsp;
    logic [2:0] mode_q = 3'h0;
    logic wake = 1'b0;
    logic por = 1'b0;
    logic powerup_delay_timer_en = 1'b0;
    logic powerup_delay_timer_exp = 1'b1;
    logic osc_en = 1'b0;
    logic osc, cpu_hold, pin4_o, pin4_oe, pin4_gpio, pin5_gpio, irq;
    ccs_src_t src;
    ccs_gain_t gain;
    int edges, base, n;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] rd;

    always #50 clk = ~clk;

    ccs_clock_ctrl #(.FAIL_TIMEOUT(16)) u_ccs_clock_ctrl (.clk(clk), .rst(rst),
        .wb_req(wb_req), .wb_rsp(wb_rsp), .clock_mode_select(mode_q), .osc_input_pin(osc),
        .por_event(por), .wake_event(wake), .powerup_delay_timer_enable(powerup_delay_timer_en), .powerup_delay_timer_expired(powerup_delay_timer_exp),
        .cpu_hold(cpu_hold), .sysclk_source(src), .amp_gain(gain), .pin4_o(pin4_o),
        .pin4_oe(pin4_oe), .pin4_gpio(pin4_gpio), .pin5_gpio(pin5_gpio), .irq(irq));
    ccs_osc_model u_ccs_osc_model (.clk(clk), .rst(rst), .en(osc_en), .osc(osc),
        .edges(edges));

    task automatic tally_and_finish();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    task automatic timed_out();
        $display("MISMATCH t=%0t got=%h exp=%h wait expired", $time, 1'b0, 1'b1);
        n_mismatch++;
        tally_and_finish();
    endtask : timed_out

    // Classic single cycle; read data is taken at the ack edge only
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int i;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wb_rsp.ack === 1'b1) break;
        end
        if (i == 20) timed_out();
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb

    task automatic do_reset(input logic [2:0] m);
        @(posedge clk);
        osc_en <= 1'b0;
        mode_q <= m;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic wait_edges(input int target);
        int i;
        for (i = 0; i < 10000 && edges < target; i++) @(negedge clk);
        if (i == 10000) timed_out();
    endtask : wait_edges

    task automatic pulse_wake();
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
    endtask : pulse_wake

    task automatic count_rises(input int cycles);
        logic last;
        n = 0;
        last = pin4_o;
        repeat (cycles) begin
            @(negedge clk);
            if (pin4_o === 1'b1 && last === 1'b0) n++;
            last = pin4_o;
        end
    endtask : count_rises

    initial begin
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            osc_en <= 1'b1;
            repeat (80) @(negedge clk);
            chk(gain, (m >= 1 && m <= 3) ? m : 0);
            chk(pin4_gpio, 32'(8'ha1 >> m) & 1);
            if (m == 0 || m >= 4) chk(pin4_oe, 32'(8'h50 >> m) & 1);
            chk(pin5_gpio, m >= 6);
            wb(1'b0, REG_STAT, 0);
            chk(rd[2:0], m);
            if (m == 6) begin
                count_rises(40);
                chk(n, 10);
            end
            if (m == 4) begin
                count_rises(64);
                chk(n, 4);
            end
        end
        // Internal mode: fixed wait after wake, then a done flag
        wb(1'b1, REG_IRQ_STAT, 32'h4);
        pulse_wake();
        @(negedge clk);
        for (n = 0; n < 200 && cpu_hold === 1'b1; n++) @(negedge clk);
        if (n == 200) timed_out();
        chk(n, 50);
        wb(1'b0, REG_IRQ_STAT, 0);
        chk(rd[2], 1);
        // Crystal: count restarted by a wake in mid-count
        do_reset(3'h2);
        osc_en <= 1'b1;
        wait_edges(500);
        chk(cpu_hold, 1);
        pulse_wake();
        base = edges;
        wait_edges(base + 1000);
        chk(cpu_hold, 1);
        for (n = 0; n < 2000 && cpu_hold !== 1'b0; n++) @(negedge clk);
        if (n == 2000) timed_out();
        chk((edges - base >= 1023) && (edges - base <= 1025), 1);
        wb(1'b0, REG_IRQ_STAT, 0);
        chk(rd[0], 1);
        // Two-speed: code runs on the internal clock while the count restarts
        wb(1'b1, REG_CTRL, 32'h2);
        pulse_wake();
        @(negedge clk);
        chk(cpu_hold, 0);
        chk(src, SRC_FAST_INT);
        wb(1'b0, REG_STAT, 0);
        chk(rd[5], 1);
        wb(1'b1, REG_CTRL, 32'h0);
        @(negedge clk);
        chk(cpu_hold, 1);
        // Power-on: the count waits for the power-up delay to expire
        @(posedge clk);
        powerup_delay_timer_en <= 1'b1;
        powerup_delay_timer_exp <= 1'b0;
        por <= 1'b1;
        @(posedge clk);
        por <= 1'b0;
        repeat (20) @(negedge clk);
        chk(cpu_hold, 1);
        wb(1'b0, REG_STAT, 0);
        chk(rd[5], 0);
        powerup_delay_timer_exp <= 1'b1;
        wb(1'b0, REG_STAT, 0);
        chk(rd[5], 1);
        // External clock: no start-up hold, source select, clock loss
        do_reset(3'h0);
        osc_en <= 1'b1;
        repeat (40) @(negedge clk);
        chk(cpu_hold, 0);
        chk(src, SRC_EXT);
        pulse_wake();
        @(negedge clk);
        chk(cpu_hold, 0);
        wb(1'b1, REG_CTRL, 32'h1);
        wb(1'b0, REG_CTRL, 0);
        chk(rd, 32'h1);
        chk(src, SRC_FAST_INT);
        wb(1'b1, REG_CTRL, 32'h5);
        @(negedge clk);
        chk(src, SRC_SLOW_INT);
        wb(1'b1, REG_CTRL, 32'h0);
        wb(1'b0, 8'h10, 0);
        chk(rd, 0);
        wb(1'b1, REG_IRQ_MASK, 32'h2);
        chk(irq, 0);
        osc_en <= 1'b0;
        repeat (40) @(negedge clk);
        chk(src, SRC_FAST_INT);
        chk(irq, 1);
        wb(1'b0, REG_STAT, 0);
        chk(rd[4], 1);
        wb(1'b1, REG_IRQ_STAT, 32'h2);
        @(negedge clk);
        chk(irq, 0);
        tally_and_finish();
    end
endmodule : clock_source_mode_startup_tb_top
